// ===== sim/utx_rx_model.sv
// Remote serial node that samples the transmit line at mid-bit.
`timescale 1ns/1ps
module utx_rx_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic baud_tick,
	input wire logic line,
	input wire logic invert,
	input wire logic done,
	output logic [15:0] frame
);
	logic [15:0] hist;
	logic [3:0] cnt;
	// Bits are taken half a bit time after each tick, newest at bit 0.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 4'h0;
			hist <= 16'hffff;
			frame <= 16'h0000;
		end else begin
			if (baud_tick)
				cnt <= 4'h1;
			else if (cnt != 4'h0)
				cnt <= cnt + 4'h1;
			if (cnt == 4'h4)
				hist <= {hist[14:0], line ^ invert};
			if (done)
				frame <= hist;
		end
	end
endmodule

// ===== sim/utx_top_test.sv
// Self-checking bench for the UART transmitter.
`timescale 1ns/1ps
module utx_top_test;
	logic clk, rst, baud_tick, avs_read, avs_write, inv;
	logic avs_waitrequest, serial_out_pin, tx_done_event;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [15:0] frame;
	logic [2:0] bcnt;
	int n_fail, comparisons;
	utx_top utx_top_inst (.clk(clk), .rst(rst), .baud_tick(baud_tick),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.serial_out_pin(serial_out_pin), .tx_done_event(tx_done_event));
	utx_rx_model utx_rx_model_inst (.clk(clk), .rst(rst),
		.baud_tick(baud_tick), .line(serial_out_pin), .invert(inv),
		.done(tx_done_event), .frame(frame));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		bcnt <= bcnt + 3'h1;
		baud_tick <= (bcnt == 3'h7);
	end
	// ----
	// Helpers.
	// ----
	task tally_and_finish;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i == 50) begin
			n_fail++;
			tally_and_finish();
		end
		@(posedge clk);
	endtask
	task wait_done;
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge clk);
			if (tx_done_event === 1'b1)
				break;
		end
		if (i == 400) begin
			n_fail++;
			tally_and_finish();
		end
		@(posedge clk);
	endtask
	// Frame bits in line order, start first, with the count of bits.
	task exp_frame(input logic [7:0] d, m, input logic msbf,
		output logic [15:0] e, output int n);
		int i, w;
		logic p;
		w = m[2] ? 8 : 7;
		e = 16'h0000;
		p = ^(d & (m[2] ? 8'hff : 8'h7f));
		for (i = 0; i < w; i++)
			e = {e[14:0], msbf ? d[w - 1 - i] : d[i]};
		if (m[4:3] != 2'h0)
			e = {e[14:0], m[4] & (p ^ ~m[3])};
		e = {e[14:0], 1'b1};
		if (m[1])
			e = {e[14:0], 1'b1};
		n = w + 2 + (m[4:3] != 2'h0) + m[1];
	endtask
	task check_frame(input logic [7:0] d, m, input logic msbf);
		logic [15:0] e;
		int n;
		exp_frame(d, m, msbf, e, n);
		check("frame", 32'(frame & ((16'h1 << n) - 16'h1)), 32'(e));
	endtask
	// ----
	// Scenarios.
	// ----
	task send(input logic [7:0] m, input logic [1:0] c, input logic [7:0] d);
		inv <= c[0];
		bus(1'b1, 5'h04, {30'h0, c});
		bus(1'b1, 5'h00, 32'h80);
		bus(1'b1, 5'h00, {24'h0, m | 8'hc0});
		bus(1'b1, 5'h08, {24'h0, d});
		wait_done();
		check_frame(d, m, c[1]);
		check("idle", 32'(serial_out_pin), 32'(!c[0]));
	endtask
	task reset_and_enable;
		check("pin", 32'(serial_out_pin), 32'h1);
		bus(1'b0, 5'h00, 32'h0);
		check("mode", q, 32'h01);
		bus(1'b0, 5'h14, 32'h0);
		check("unmapped", q, 32'h0);
		bus(1'b1, 5'h00, 32'h80);
		check("pin on", 32'(serial_out_pin), 32'h1);
		bus(1'b1, 5'h08, 32'h33);
		bus(1'b0, 5'h0c, 32'h0);
		check("status", q, 32'h0);
	endtask
	task rx_parity;
		for (int p = 0; p < 4; p++) begin
			bus(1'b1, 5'h00, {24'h0, 8'h84 | 8'(p << 3)});
			bus(1'b1, 5'h10, 32'h001);
			bus(1'b0, 5'h10, 32'h0);
			check("perr1", 32'(q[16]), 32'(p == 3));
			bus(1'b1, 5'h10, 32'h003);
			bus(1'b0, 5'h10, 32'h0);
			check("perr2", 32'(q[16]), 32'(p == 2));
		end
	endtask
	task back_to_back;
		bus(1'b1, 5'h00, 32'hc4);
		bus(1'b0, 5'h0c, 32'h0);
		check("status idle", q, 32'h0);
		bus(1'b1, 5'h08, 32'h11);
		bus(1'b0, 5'h0c, 32'h0);
		check("status a", 32'(q[1:0]), 32'h1);
		bus(1'b1, 5'h08, 32'h22);
		bus(1'b0, 5'h0c, 32'h0);
		check("status b", 32'(q[1:0]), 32'h3);
		wait_done();
		check_frame(8'h11, 8'h04, 1'b0);
		wait_done();
		check_frame(8'h22, 8'h04, 1'b0);
		bus(1'b0, 5'h0c, 32'h0);
		check("status c", q, 32'h0);
	endtask
	task clock_off;
		int i;
		bus(1'b1, 5'h08, 32'h5a);
		for (i = 0; i < 100 && serial_out_pin !== 1'b0; i++)
			@(posedge clk);
		check("start", 32'(serial_out_pin), 32'h0);
		bus(1'b1, 5'h00, 32'h00);
		check("pin off", 32'(serial_out_pin), 32'h1);
		bus(1'b0, 5'h0c, 32'h0);
		check("status off", q, 32'h0);
	endtask
	initial begin
		rst = 1'b1;
		bcnt = 3'h0;
		baud_tick = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		inv = 1'b0;
		n_fail = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		reset_and_enable();
		for (int p = 0; p < 4; p++)
			send(8'h04 | 8'(p << 3), 2'h0, 8'hb5);
		send(8'h12, 2'h0, 8'h36);
		send(8'h1c, 2'h2, 8'h55);
		send(8'h1c, 2'h1, 8'h55);
		inv <= 1'b0;
		bus(1'b1, 5'h04, 32'h0);
		rx_parity();
		back_to_back();
		clock_off();
		tally_and_finish();
	end
endmodule

// ===== src/utx_defs.svh
// Offsets, field positions, reset values and codes of the transmitter.
`ifndef UTX_DEFS_SVH
`define UTX_DEFS_SVH
`define UTX_OFF_MODE 5'h00
`define UTX_OFF_CTRL 5'h04
`define UTX_OFF_TXBUF 5'h08
`define UTX_OFF_STATUS 5'h0c
`define UTX_OFF_RXCHK 5'h10
`define UTX_MODE_RESET 8'h01
`define UTX_CTRL_RESET 8'h00
`define UTX_MODE_OPCLK 7
`define UTX_MODE_TXEN 6
`define UTX_MODE_PS_HI 4
`define UTX_MODE_PS_LO 3
`define UTX_MODE_LEN8 2
`define UTX_MODE_STOP2 1
`define UTX_CTRL_MSBF 1
`define UTX_CTRL_INV 0
`define UTX_STAT_BUF 1
`define UTX_STAT_SHIFT 0
`define UTX_PAR_NONE 2'h0
`define UTX_PAR_ZERO 2'h1
`define UTX_PAR_ODD 2'h2
`define UTX_PAR_EVEN 2'h3
`endif

// ===== src/utx_pkg.sv
// Types shared by the UART transmitter.
package utx_pkg;
	typedef enum logic [2:0] {
		UTX_IDLE = 3'b000,
		UTX_START = 3'b001,
		UTX_DATA = 3'b010,
		UTX_PARITY = 3'b011,
		UTX_STOP = 3'b100
	} utx_state_t;
endpackage

// ===== src/utx_top.sv
// UART transmitter with parity, double buffering and an Avalon-MM slave.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "utx_defs.svh"

// Behaviour
// R1 - even parity sets one on odd count
// R2 - even check flags error on odd count
// R3 - odd parity sets zero on odd count
// R4 - odd check flags error on even count
// R5 - zero parity sends zero, never checked
// R6 - no parity omits bit, no error
// R7 - clock enable makes line idle high
// R8 - enabled buffer write starts a frame
// R9 - buffer copies to shift register, shifts out
// R10 - done event after last stop bit
// R11 - idle high until next buffer write
// R12 - buffer refills once shifting has begun
// R13 - status bit 1 is buffer occupied
// R14 - status bit 0 is shift busy
// R15 - flags pass 10, 11, 01
// R16 - software writes only when buffer free
// R17 - software waits done before reinitialising
// R18 - LIN software uses no parity
// R19 - LIN software waits status zero
// R20 - seven bits, parity, two stops, LSB first
// R21 - frame of start, 7/8, parity, 1/2 stop
// R22 - control bit 1 selects bit order
// R23 - control bit 0 inverts output
// R24 - clock disable resets circuit, line high
// R25 - parity select code 00 means none
// R26 - shift advances one bit per tick
module utx_top (
	input wire logic clk,
	input wire logic rst,
	input wire logic baud_tick,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic serial_out_pin,
	output logic tx_done_event
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] mode_register_reg, mode_register_next;
	logic [7:0] control_register_reg, control_register_next;
	logic [7:0] tx_buffer_reg, tx_buffer_next;
	logic buf_full_reg, buf_full_next;
	logic [7:0] tx_shift_reg_reg, tx_shift_reg_next;
	logic busy_reg, busy_next;
	utx_pkg::utx_state_t state_reg, state_next;
	logic [2:0] bitcnt_reg, bitcnt_next;
	logic stopcnt_reg, stopcnt_next;
	logic par_reg, par_next;
	logic line_reg, line_next;
	logic pin_reg, pin_next;
	logic done_reg, done_next;
	logic tail_reg, tail_next;
	logic waitreq_reg;
	logic [31:0] rdata_reg, rdata_next;
	logic ack_reg, ack_next;
	logic [8:0] chk_reg, chk_next;
	logic perr_reg, perr_next;

	logic opclk, txen, len8, stop2, msbf, inv;
	logic [1:0] psel;
	logic access, wr_buf;
	logic [7:0] dmask;
	logic chk_ones;

	assign opclk = mode_register_reg[`UTX_MODE_OPCLK];
	assign txen = mode_register_reg[`UTX_MODE_TXEN];
	assign psel = {mode_register_reg[`UTX_MODE_PS_HI],
		mode_register_reg[`UTX_MODE_PS_LO]}; // R25
	assign len8 = mode_register_reg[`UTX_MODE_LEN8];
	assign stop2 = mode_register_reg[`UTX_MODE_STOP2];
	assign msbf = control_register_reg[`UTX_CTRL_MSBF];
	assign inv = control_register_reg[`UTX_CTRL_INV];
	assign access = (avs_read || avs_write) && !ack_reg;
	assign wr_buf = access && avs_write && avs_byteenable[0]
		&& (avs_address == `UTX_OFF_TXBUF);
	assign dmask = len8 ? 8'hff : 8'h7f;
	assign chk_ones = ^(chk_reg[7:0] & dmask) ^ chk_reg[8];

	// ------------------------------------------------------------
	// Bus slave and transmitter
	// ------------------------------------------------------------
	always_comb begin
		mode_register_next = mode_register_reg;
		control_register_next = control_register_reg;
		tx_buffer_next = tx_buffer_reg;
		buf_full_next = buf_full_reg;
		tx_shift_reg_next = tx_shift_reg_reg;
		busy_next = busy_reg;
		state_next = state_reg;
		bitcnt_next = bitcnt_reg;
		stopcnt_next = stopcnt_reg;
		par_next = par_reg;
		line_next = line_reg;
		done_next = 1'b0;
		tail_next = tail_reg;
		rdata_next = 32'h0000_0000;
		ack_next = access;
		chk_next = chk_reg;
		perr_next = perr_reg;
		if (access && avs_write && avs_byteenable[0]) begin
			if (avs_address == `UTX_OFF_MODE) begin
				mode_register_next = avs_writedata[7:0];
			end else if (avs_address == `UTX_OFF_CTRL) begin
				control_register_next = avs_writedata[7:0];
			end else if (avs_address == `UTX_OFF_RXCHK) begin
				chk_next = avs_writedata[8:0];
			end
		end
		if (access && avs_read) begin
			if (avs_address == `UTX_OFF_MODE) begin
				rdata_next = {24'h000000, mode_register_reg};
			end else if (avs_address == `UTX_OFF_CTRL) begin
				rdata_next = {24'h000000, control_register_reg};
			end else if (avs_address == `UTX_OFF_TXBUF) begin
				rdata_next = {24'h000000, tx_buffer_reg};
			end else if (avs_address == `UTX_OFF_STATUS) begin
				rdata_next = {30'h0, buf_full_reg, busy_reg}; // R13 R14 R15
			end else if (avs_address == `UTX_OFF_RXCHK) begin
				rdata_next = {15'h0000, perr_reg, 7'h00, chk_reg};
			end else begin
				rdata_next = 32'h0000_0000;
			end
		end
		// Parity check of a received data word and parity bit.
		if (psel == `UTX_PAR_EVEN) begin
			perr_next = chk_ones; // R2
		end else if (psel == `UTX_PAR_ODD) begin
			perr_next = !chk_ones; // R4
		end else begin
			perr_next = 1'b0; // R5 R6
		end
		if (txen && wr_buf) begin
			tx_buffer_next = avs_writedata[7:0]; // R8
			buf_full_next = 1'b1;
		end
		// A frame stays busy through its last stop bit; the next tick ends it.
		if (tail_reg && baud_tick) begin
			tail_next = 1'b0;
			busy_next = state_reg != utx_pkg::UTX_IDLE;
			done_next = 1'b1; // R10
		end
		case (state_reg)
			utx_pkg::UTX_IDLE: begin
				line_next = 1'b1; // R7 R11
				if (buf_full_reg && txen) begin
					tx_shift_reg_next = tx_buffer_reg; // R9
					buf_full_next = wr_buf; // R12
					busy_next = 1'b1;
					case (psel)
						`UTX_PAR_EVEN: par_next = ^(tx_buffer_reg & dmask); // R1
						`UTX_PAR_ODD: par_next = ~^(tx_buffer_reg & dmask); // R3
						default: par_next = 1'b0; // R5
					endcase
					state_next = utx_pkg::UTX_START;
				end
			end
			utx_pkg::UTX_START: begin
				if (baud_tick) begin // R26
					line_next = 1'b0;
					bitcnt_next = len8 ? 3'h7 : 3'h6; // R21
					state_next = utx_pkg::UTX_DATA;
				end
			end
			utx_pkg::UTX_DATA: begin
				if (baud_tick) begin // R26
					line_next = msbf ? tx_shift_reg_reg[bitcnt_reg]
						: tx_shift_reg_reg[0]; // R22 R20
					if (!msbf) begin
						tx_shift_reg_next = {1'b0, tx_shift_reg_reg[7:1]};
					end
					bitcnt_next = bitcnt_reg - 3'h1;
					if (bitcnt_reg == 3'h0) begin
						state_next = (psel == `UTX_PAR_NONE) ? // R6
							utx_pkg::UTX_STOP : utx_pkg::UTX_PARITY;
						stopcnt_next = stop2; // R21
					end
				end
			end
			utx_pkg::UTX_PARITY: begin
				if (baud_tick) begin
					line_next = par_reg;
					state_next = utx_pkg::UTX_STOP;
				end
			end
			utx_pkg::UTX_STOP: begin
				if (baud_tick) begin
					line_next = 1'b1;
					if (stopcnt_reg) begin
						stopcnt_next = 1'b0;
					end else begin
						state_next = utx_pkg::UTX_IDLE;
						tail_next = 1'b1;
					end
				end
			end
			default: state_next = utx_pkg::UTX_IDLE;
		endcase
		if (!txen) begin
			state_next = utx_pkg::UTX_IDLE;
			buf_full_next = 1'b0;
			busy_next = 1'b0;
			line_next = 1'b1;
			done_next = 1'b0;
			tail_next = 1'b0;
		end
		pin_next = opclk ? (line_next ^ inv) : 1'b1; // R23 R24
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_register_reg <= `UTX_MODE_RESET;
			control_register_reg <= `UTX_CTRL_RESET;
			rdata_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
			waitreq_reg <= 1'b1;
			chk_reg <= 9'h000;
		end else begin
			mode_register_reg <= mode_register_next;
			control_register_reg <= control_register_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
			waitreq_reg <= !ack_next;
			chk_reg <= chk_next;
		end
	end

	// Transmit state, status and done flags and line are held in reset while the operation clock is off; buffer and shift data are kept, perr_reg still updates.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_buffer_reg <= 8'h00;
			buf_full_reg <= 1'b0;
			tx_shift_reg_reg <= 8'h00;
			busy_reg <= 1'b0;
			state_reg <= utx_pkg::UTX_IDLE;
			bitcnt_reg <= 3'h0;
			stopcnt_reg <= 1'b0;
			par_reg <= 1'b0;
			line_reg <= 1'b1;
			pin_reg <= 1'b1;
			done_reg <= 1'b0;
			tail_reg <= 1'b0;
			perr_reg <= 1'b0;
		end else if (!opclk) begin
			buf_full_reg <= 1'b0; // R24
			busy_reg <= 1'b0;
			state_reg <= utx_pkg::UTX_IDLE;
			stopcnt_reg <= 1'b0;
			line_reg <= 1'b1;
			pin_reg <= 1'b1;
			done_reg <= 1'b0;
			tail_reg <= 1'b0;
			perr_reg <= perr_next;
		end else begin
			tx_buffer_reg <= tx_buffer_next;
			buf_full_reg <= buf_full_next;
			tx_shift_reg_reg <= tx_shift_reg_next;
			busy_reg <= busy_next;
			state_reg <= state_next;
			bitcnt_reg <= bitcnt_next;
			stopcnt_reg <= stopcnt_next;
			par_reg <= par_next;
			line_reg <= line_next;
			pin_reg <= pin_next;
			done_reg <= done_next;
			tail_reg <= tail_next;
			perr_reg <= perr_next;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = waitreq_reg;
	assign serial_out_pin = pin_reg;
	assign tx_done_event = done_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_IDLE_HIGH: assert property (!opclk |=> serial_out_pin) // R24
		else $error("line not high with clock enable off");
	AST_IDLE_TX: assert property (opclk && !txen
		|=> serial_out_pin == !$past(inv)) // R7
		else $error("idle level wrong");
	AST_EVEN: assert property (state_reg == utx_pkg::UTX_START
		&& psel == `UTX_PAR_EVEN |-> par_reg == ^(tx_shift_reg_reg & dmask)) // R1
		else $error("even parity wrong");
	AST_ODD: assert property (state_reg == utx_pkg::UTX_START
		&& psel == `UTX_PAR_ODD |-> par_reg != ^(tx_shift_reg_reg & dmask)) // R3
		else $error("odd parity wrong");
	AST_ZERO: assert property (state_reg == utx_pkg::UTX_PARITY
		&& psel == `UTX_PAR_ZERO |-> !par_reg) // R5
		else $error("zero parity not zero");
	AST_NOPAR: assert property (psel == `UTX_PAR_NONE
		|-> state_reg != utx_pkg::UTX_PARITY) // R6
		else $error("parity sent with none");
	AST_DONE: assert property (tail_reg && baud_tick && opclk && txen
		|=> tx_done_event) // R10
		else $error("done event missing");
	AST_LOAD: assert property (opclk && txen && state_reg == utx_pkg::UTX_IDLE
		&& buf_full_reg |=> buf_full_reg == $past(wr_buf)) // R12
		else $error("buffer not freed at load");
	AST_PERR: assert property (psel == `UTX_PAR_EVEN
		|=> perr_reg == $past(chk_ones)) // R2
		else $error("parity check wrong");
	AST_BUS: assert property (access |=> !avs_waitrequest) // bus timing, added by the designer
		else $error("bus answer late");
	COV_FRAME: cover property (tx_done_event);
	COV_BACK: cover property (buf_full_reg && busy_reg);
	COV_TWOSTOP: cover property (stop2 && tx_done_event);
endmodule
